// ===== dv/cpu_address_map_reset_vector_test.sv
`timescale 1ns/1ps
module cpu_address_map_reset_vector_test;
  import cpuam_pkg::*;
  localparam logic [13:0] VEC = 14'h2345;
  typedef struct {
    logic [3:0]  op;
    logic [1:0]  am;
    logic        idx;
    logic [13:0] base;
    logic [7:0]  imm;
    logic [7:0]  w;
    logic [7:0]  sp;
  } cpuam_tbrow_s;
  logic         clk_sys;
  logic         rst;
  logic         op_valid;
  logic         op_ready;
  cpuam_op_e    op_code;
  cpuam_am_e    op_mode;
  cpuam_idx_e   op_idx;
  logic [13:0]  op_base;
  logic [7:0]   op_imm;
  logic [13:0]  rom_addr;
  logic [7:0]   rom_data;
  logic [7:0]   pca_rdata;
  cpuam_pca_s   pca_o;
  cpuam_state_s state_o;
  int           failures;
  int           n_checks;
  // Each row but the last is checked at the next take edge, when its result stands.
  // rows
  cpuam_tbrow_s rows [28] = '{
    '{4'h7,2'h0,1'b0,14'h0000,8'h1f,8'hxx,8'h1f},
    '{4'h1,2'h0,1'b0,14'h2010,8'h00,8'h4a,8'h1f},
    '{4'h3,2'h0,1'b0,14'h0000,8'h00,8'h4a,8'h1e},
    '{4'h1,2'h0,1'b0,14'h2020,8'h00,8'h7a,8'h1e},
    '{4'h1,2'h0,1'b0,14'h011f,8'h00,8'h4a,8'h1e},
    '{4'h2,2'h0,1'b0,14'h00a0,8'h00,8'h4a,8'h1e},
    '{4'h5,2'h0,1'b0,14'h0000,8'h7f,8'h4a,8'h1e},
    '{4'h1,2'h0,1'b0,14'h2030,8'h00,8'h6a,8'h1e},
    '{4'h1,2'h1,1'b0,14'h0021,8'h00,8'h4a,8'h1e},
    '{4'h1,2'h0,1'b0,14'h2030,8'h00,8'h6a,8'h1e},
    '{4'h4,2'h0,1'b0,14'h0000,8'h00,8'h4a,8'h1f},
    '{4'h1,2'h0,1'b0,14'h207a,8'h00,8'h20,8'h1f},
    '{4'h2,2'h0,1'b0,14'h00b0,8'h00,8'h20,8'h1f},
    '{4'h2,2'h0,1'b0,14'h00b1,8'h00,8'h20,8'h1f},
    '{4'h6,2'h0,1'b1,14'h0000,8'h01,8'h20,8'h1f},
    '{4'h1,2'h2,1'b0,14'h0031,8'h00,8'h7a,8'h1f},
    '{4'h1,2'h3,1'b1,14'h00b0,8'h00,8'h7b,8'h1f},
    '{4'h2,2'h0,1'b0,14'h00ff,8'h00,8'h7b,8'h1f},
    '{4'h1,2'h0,1'b0,14'h2030,8'h00,8'h6a,8'h1f},
    '{4'h1,2'h0,1'b0,14'h00ff,8'h00,8'h7b,8'h1f},
    '{4'h2,2'h0,1'b0,14'h0010,8'h00,8'h7b,8'h1f},
    '{4'h1,2'h0,1'b0,14'h2030,8'h00,8'h6a,8'h1f},
    '{4'h1,2'h0,1'b0,14'h0010,8'h00,8'h7b,8'h1f},
    '{4'h1,2'h0,1'b0,14'h0120,8'h00,8'h00,8'h1f},
    '{4'h9,2'h0,1'b0,14'h0000,8'h00,8'h7f,8'h1f},
    '{4'h1,2'h1,1'b0,14'h00a0,8'h00,8'h4a,8'h1f},
    '{4'h8,2'h0,1'b0,14'h00a0,8'h00,8'h94,8'h1f},
    '{4'h0,2'h0,1'b0,14'h0000,8'h00,8'hxx,8'h1f}};

  cpuam_core i_cpuam_core (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .op_valid (op_valid),
    .op_code  (op_code),
    .op_mode  (op_mode),
    .op_idx   (op_idx),
    .op_base  (op_base),
    .op_imm   (op_imm),
    .op_ready (op_ready),
    .rom_addr (rom_addr),
    .rom_data (rom_data),
    .pca_o    (pca_o),
    .pca_rdata(pca_rdata),
    .state_o  (state_o)
  );
  cpuam_mem_model #(.VEC(VEC)) i_cpuam_mem_model (
    .clk_sys  (clk_sys),
    .rom_addr (rom_addr),
    .rom_data (rom_data),
    .pca_o    (pca_o),
    .pca_rdata(pca_rdata)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish(input bit timed_out);
    if (timed_out) failures++;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Returns at the edge that takes the operation. Fields change one edge
  // later, since the core still reads the immediate while it executes.
  task automatic issue(input cpuam_tbrow_s r);
    int n;
    @(posedge clk_sys);
    op_code  <= cpuam_op_e'(r.op);
    op_mode  <= cpuam_am_e'(r.am);
    op_idx   <= cpuam_idx_e'({1'b0, r.idx});
    op_base  <= r.base;
    op_imm   <= r.imm;
    op_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (op_ready !== 1'b1 && n < 20);
    if (op_ready !== 1'b1) tally_and_finish(1'b1);
  endtask : issue

  task automatic go(input logic [3:0] op, input logic [13:0] base,
                    input logic [7:0] imm);
    issue('{op, 2'h0, 1'b0, base, imm, 8'h00, 8'h00});
  endtask : go

  task automatic do_reset();
    int n;
    rst      <= 1'b1;
    op_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(rom_addr, RST_VEC_LO);
    chk(op_ready, 1'b0);
    rst <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (op_ready !== 1'b1 && n < 10);
    if (op_ready !== 1'b1) tally_and_finish(1'b1);
    chk(state_o.pc, VEC);
  endtask : do_reset

  initial begin
    rst      = 1'b1;
    op_valid = 1'b0;
    op_code  = CPUAM_OP_NOP;
    op_mode  = CPUAM_AM_ABS;
    op_idx   = CPUAM_REG_X;
    op_base  = 14'h0000;
    op_imm   = 8'h00;
    failures = 0;
    n_checks = 0;
    do_reset();
    for (int i = 0; i < 28; i++) begin
      issue(rows[i]);
      if (i > 0 && rows[i-1].w !== 8'hxx) chk(state_o.work, rows[i-1].w);
      if (i > 0) chk(state_o.sp, rows[i-1].sp);
    end
    go(4'ha, 14'h3fff, 8'h00);
    go(4'hc, 14'h0000, 8'h02);
    chk(state_o.pc, 14'h3fff);
    go(4'hb, 14'h2200, 8'h00);
    chk(state_o.flags, (8'h02 & FLAGS_MASK) | FLAGS_RST);
    go(4'hc, 14'h0000, 8'h00);
    chk(state_o.pc, 14'h2200);
    go(4'hb, 14'h2300, 8'h00);
    chk(state_o.flags, FLAGS_RST);
    go(4'h0, 14'h0000, 8'h00);
    // Two more operations stepped the counter and the branch was not taken.
    chk(state_o.pc, 14'h2202);
    // second reset, pointer wraps at zero
    do_reset();
    go(4'h1, 14'h2010, 8'h00);
    go(4'h7, 14'h0000, 8'h00);
    go(4'h3, 14'h0000, 8'h00);
    go(4'h1, 14'h2020, 8'h00);
    chk(state_o.sp, 8'hff);
    go(4'h4, 14'h0000, 8'h00);
    go(4'h1, 14'h0100, 8'h00);
    chk(state_o.sp, 8'h00);
    chk(state_o.work, 8'h4a);
    go(4'h0, 14'h0000, 8'h00);
    chk(state_o.work, 8'h4a);
    op_valid <= 1'b0;
    tally_and_finish(1'b0);
  end
endmodule : cpu_address_map_reset_vector_test

// ===== dv/cpuam_mem_model.sv
`timescale 1ns/1ps
module cpuam_mem_model #(
  parameter logic [13:0] VEC = 14'h2345
) (
  // Clock
  input  wire logic             clk_sys,
  // Program store
  input  wire logic [13:0]      rom_addr,
  output logic      [7:0]       rom_data,
  // Peripheral control area
  input  cpuam_pkg::cpuam_pca_s pca_o,
  output logic      [7:0]       pca_rdata
);
  import cpuam_pkg::*;
  logic [7:0] pca_mem [0:34];
  logic       rom_sel;
  logic       pca_sel;
  logic       pca_wr;
  assign rom_sel = (rom_addr >= ROM_LO) && (rom_addr <= ROM_HI);
  // Unselected reads return the inverted address, so a stale value never passes.
  // vector bytes
  assign rom_data = !rom_sel ? ~rom_addr[7:0] :
                    (rom_addr == RST_VEC_LO) ? VEC[7:0] :
                    (rom_addr == RST_VEC_HI) ? {2'h0, VEC[13:8]} :
                    rom_addr[7:0] ^ 8'h5a;
  assign pca_sel = pca_o.addr <= PCA_HI;
  assign pca_wr = pca_o.req && pca_o.wr && pca_sel;
  assign pca_rdata = pca_sel ? pca_mem[pca_o.addr[5:0]] : ~pca_o.addr[7:0];
  initial begin
    for (int i = 0; i < 35; i++) begin
      pca_mem[i] = 8'h00;
    end
  end
  // A plain always, since the initial block also fills this array.
  always @(posedge clk_sys) begin
    if (pca_wr) begin
      pca_mem[pca_o.addr[5:0]] <= pca_o.wdata;
    end
  end
endmodule : cpuam_mem_model

// ===== hdl/cpuam_core.sv
`timescale 1ns/1ps
module cpuam_core #(
  parameter int ROM_WORDS = cpuam_pkg::ROM_DEPTH
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // Instruction stream from the sequencer
  input  wire logic                   op_valid,
  input  cpuam_pkg::cpuam_op_e        op_code,
  input  cpuam_pkg::cpuam_am_e        op_mode,
  input  cpuam_pkg::cpuam_idx_e       op_idx,
  input  wire logic [13:0]            op_base,
  input  wire logic [7:0]             op_imm,
  output logic                        op_ready,
  // Program store read port
  output logic [13:0]                 rom_addr,
  input  wire logic [7:0]             rom_data,
  // Peripheral control area access
  output cpuam_pkg::cpuam_pca_s       pca_o,
  input  wire logic [7:0]             pca_rdata,
  // Core state view
  output cpuam_pkg::cpuam_state_s     state_o
);
  import cpuam_pkg::*;

  typedef enum logic [5:0] {
    S_VLO  = 6'b000001,
    S_VHI  = 6'b000010,
    S_IDLE = 6'b000100,
    S_PLO  = 6'b001000,
    S_PHI  = 6'b010000,
    S_EXEC = 6'b100000
  } cpuam_st_e;

  localparam int RAM_AW = $clog2(RAM_DEPTH);

  function automatic logic [13:0] add_idx(input logic [13:0] b,
                                          input logic [7:0] i);
    add_idx = b + {6'h00, i};
  endfunction : add_idx

  function automatic logic [RAM_AW-1:0] ram_idx(input logic [13:0] a);
    logic [13:0] off;
    off = a - RAM_LO;
    ram_idx = off[RAM_AW-1:0];
  endfunction : ram_idx

  function automatic logic ctl_op(input cpuam_op_e o);
    ctl_op = (o == CPUAM_OP_LDW) || (o == CPUAM_OP_STW);
  endfunction : ctl_op

  cpuam_st_e   st_r, st_nxt;
  logic [13:0] pc_r;
  logic [7:0]  work_r, x_r, y_r, sp_r, flags_r, vlo_r, ptr_lo_r;
  logic [13:0] ptr_r, ea_r, rom_addr_r;
  logic        ready_r;
  cpuam_pca_s  pca_r;
  cpuam_op_e   opc_r;
  cpuam_am_e   am_r;
  cpuam_idx_e  ix_r;

  wire [7:0]  idx_val  = (op_idx == CPUAM_REG_Y) ? y_r : x_r;
  wire [7:0]  hidx_val = (ix_r == CPUAM_REG_Y) ? y_r : x_r;
  // push address is base plus pointer; pull address is base plus pointer plus one.
  wire [13:0] stk_push = STK_BASE + {6'h00, sp_r};
  wire [7:0]  sp_inc   = sp_r + 8'h01;
  wire [13:0] stk_pull = STK_BASE + {6'h00, sp_inc};
  wire [13:0] ea_idx   = add_idx(op_base, idx_val);
  wire [13:0] ptr_pre  = add_idx(op_base, idx_val);
  wire [13:0] ptr_nxt  = (op_mode == CPUAM_AM_PRE) ? ptr_pre : op_base;
  wire        take     = (st_r == S_IDLE) && op_valid;
  wire        is_stk   = (op_code == CPUAM_OP_PUSH) ||
                         (op_code == CPUAM_OP_PULL);
  wire        is_ind   = (op_mode == CPUAM_AM_PRE) ||
                         (op_mode == CPUAM_AM_POST);
  wire [13:0] ea_now   = (op_code == CPUAM_OP_PUSH) ? stk_push :
                         (op_code == CPUAM_OP_PULL) ? stk_pull :
                         (op_mode == CPUAM_AM_IDX)  ? ea_idx   : op_base;

  cpuam_dec_s  dec;
  logic [7:0]  ram_rd;
  wire [13:0]  acc_addr = (st_r == S_PLO) ? ptr_r :
                          (st_r == S_PHI) ? ptr_r + 14'h0001 : ea_r;
  wire         acc_ram  = dec.ram;
  wire [7:0]   rd_byte  = dec.ram ? ram_rd :
                          dec.rom ? rom_data :
                          dec.pca ? pca_rdata : 8'h00;
  wire         ram_we   = (st_r == S_EXEC) && dec.ram &&
                          ((opc_r == CPUAM_OP_STW) ||
                           (opc_r == CPUAM_OP_PUSH));
  wire [13:0]  ptr_ea   = {rd_byte[5:0], ptr_lo_r};
  wire [13:0]  ea_phi   = (am_r == CPUAM_AM_POST) ?
                          add_idx(ptr_ea, hidx_val) : ptr_ea;
  // The store and the control area answer combinationally to registered
  // addresses, so the next access address is launched one cycle early.
  wire [13:0]  nxt_addr = (st_r == S_PHI) ? ea_phi :
                          (st_r == S_PLO) ? ptr_r + 14'h0001 :
                          (is_ind && !is_stk) ? ptr_nxt : ea_now;
  cpuam_dec_s  dec_nxt;
  wire         pca_op   = (st_r == S_IDLE) ? ctl_op(op_code) : ctl_op(opc_r);
  wire         pca_wr   = (st_r == S_IDLE) ? (op_code == CPUAM_OP_STW) :
                          (opc_r == CPUAM_OP_STW);
  wire         pca_go   = (st_nxt == S_EXEC) && dec_nxt.pca && pca_op;

  cpuam_decode u_dec (
    .addr (acc_addr),
    .dec  (dec)
  );

  cpuam_decode u_dec_nxt (
    .addr (nxt_addr),
    .dec  (dec_nxt)
  );

  // one array for stack and data.
  cpuam_ram #(.DEPTH(RAM_DEPTH)) u_ram (
    .clk_sys (clk_sys),
    .we      (ram_we && acc_ram),
    .waddr   (ram_idx(acc_addr)),
    .wdata   (work_r),
    .raddr   (ram_idx(acc_addr)),
    .rdata   (ram_rd)
  );

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      S_VLO:  st_nxt = S_VHI;
      S_VHI:  st_nxt = S_IDLE;
      S_IDLE: begin
        if (take && is_ind && !is_stk) begin
          st_nxt = S_PLO;
        end else if (take) begin
          st_nxt = S_EXEC;
        end
      end
      S_PLO:  st_nxt = S_PHI;
      S_PHI:  st_nxt = S_EXEC;
      S_EXEC: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r       <= S_VLO;
      // vector fetch begins at low byte.
      rom_addr_r <= RST_VEC_LO;
      pc_r       <= 14'h0000;
      vlo_r      <= 8'h00;
      work_r     <= 8'h00;
      x_r        <= 8'h00;
      y_r        <= 8'h00;
      flags_r    <= FLAGS_RST;
      ready_r    <= 1'b0;
      ea_r       <= 14'h0000;
      ptr_r      <= 14'h0000;
      ptr_lo_r   <= 8'h00;
      opc_r      <= CPUAM_OP_NOP;
      am_r       <= CPUAM_AM_ABS;
      ix_r       <= CPUAM_REG_X;
      pca_r      <= '0;
    end else begin
      st_r    <= st_nxt;
      ready_r <= (st_nxt == S_IDLE);
      pca_r   <= '0;
      if (pca_go) begin
        pca_r.req   <= 1'b1;
        pca_r.wr    <= pca_wr;
        pca_r.addr  <= nxt_addr;
        pca_r.wdata <= work_r;
      end
      unique case (st_r)
        S_VLO: begin
          vlo_r      <= rom_data;
          rom_addr_r <= RST_VEC_HI;
        end
        S_VHI: begin
          pc_r <= {rom_data[5:0], vlo_r};
        end
        S_IDLE: begin
          if (take) begin
            opc_r <= op_code;
            am_r  <= op_mode;
            ix_r  <= op_idx;
            ea_r  <= ea_now;
            ptr_r <= (op_mode == CPUAM_AM_PRE) ? ptr_pre : op_base;
            pc_r  <= pc_r + 14'h0001;
            rom_addr_r <= nxt_addr;
          end
        end
        S_PLO: begin
          ptr_lo_r   <= rd_byte;
          rom_addr_r <= nxt_addr;
        end
        S_PHI: begin
          ea_r       <= ea_phi;
          rom_addr_r <= nxt_addr;
        end
        S_EXEC: begin
          if (opc_r == CPUAM_OP_LDW || opc_r == CPUAM_OP_PULL) begin
            work_r <= rd_byte;
          end else if (opc_r == CPUAM_OP_ADD) begin
            work_r <= work_r + rd_byte;
          end else if (opc_r == CPUAM_OP_XCHX) begin
            work_r <= x_r;
            x_r    <= work_r;
          end
          if (opc_r == CPUAM_OP_LDX) begin
            x_r <= op_imm;
          end
          if (opc_r == CPUAM_OP_LDY) begin
            y_r <= op_imm;
          end
          if (opc_r == CPUAM_OP_LDF) begin
            flags_r <= (op_imm & FLAGS_MASK) | FLAGS_RST;
          end else if (opc_r == CPUAM_OP_LDW || opc_r == CPUAM_OP_ADD) begin
            flags_r[1] <= (opc_r == CPUAM_OP_LDW) ? (rd_byte == 8'h00) :
                          ((work_r + rd_byte) == 8'h00);
          end
          if (opc_r == CPUAM_OP_JMP ||
              (opc_r == CPUAM_OP_BRZ && flags_r[1])) begin
            pc_r <= ea_r;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (st_r == S_EXEC) begin
      if (opc_r == CPUAM_OP_PUSH) begin
        sp_r <= sp_r - 8'h01;
      end else if (opc_r == CPUAM_OP_PULL) begin
        sp_r <= sp_inc;
      end else if (opc_r == CPUAM_OP_LDSP) begin
        sp_r <= op_imm;
      end
    end
  end

  assign op_ready      = ready_r;
  assign rom_addr      = rom_addr_r;
  assign pca_o         = pca_r;
  assign state_o.work  = work_r;
  assign state_o.flags = flags_r;
  assign state_o.sp    = sp_r;
  assign state_o.pc    = pc_r;

  reg vec_done_r;
  always_ff @(posedge clk_sys) begin
    vec_done_r <= rst ? 1'b0 : (st_r == S_VHI);
  end

  vector_load_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r == S_VHI) |=> (pc_r == {$past(rom_data[5:0]), vlo_r}))
    else $error("Reset vector not loaded.");
  vec_order_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r == S_VLO) |=> (rom_addr == RST_VEC_HI) && (st_r == S_VHI))
    else $error("Vector bytes out of order.");
  push_dec_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r == S_EXEC && opc_r == CPUAM_OP_PUSH) |=>
    (sp_r == $past(sp_r) - 8'h01))
    else $error("Push did not decrement.");
  pull_addr_a: assert property (@(posedge clk_sys) disable iff (rst)
    (take && op_code == CPUAM_OP_PULL) |=>
    (ea_r == STK_BASE + {6'h00, $past(sp_r) + 8'h01}))
    else $error("Pull address wrong.");
  rom_range_a: assert property (@(posedge clk_sys) disable iff (rst)
    dec.rom |-> (acc_addr[13:12] == 2'h2))
    else $error("Program store decode wrong.");
  rom_track_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_r == S_EXEC) |-> (rom_addr == acc_addr))
    else $error("Store address not presented.");
  ram_range_a: assert property (@(posedge clk_sys) disable iff (rst)
    dec.ram |-> (acc_addr >= 14'h00a0 && acc_addr <= 14'h011f))
    else $error("RAM decode wrong.");
  zp_range_a: assert property (@(posedge clk_sys) disable iff (rst)
    dec.zp |-> (acc_addr[13:8] == 6'h00) && !dec.stk)
    else $error("Zero page decode wrong.");
  stk_share_a: assert property (@(posedge clk_sys) disable iff (rst)
    dec.stk |-> dec.ram)
    else $error("Stack page not in RAM.");
  pca_zp_a: assert property (@(posedge clk_sys) disable iff (rst)
    pca_o.req |-> (pca_o.addr <= 14'h0022))
    else $error("Control access outside area.");
  idx_ea_a: assert property (@(posedge clk_sys) disable iff (rst)
    (take && op_mode == CPUAM_AM_IDX && !is_stk) |=>
    (ea_r == $past(op_base) + {6'h00, $past(idx_val)}))
    else $error("Indexed address wrong.");
  vec_cov_c: cover property (@(posedge clk_sys) vec_done_r);
  push_cov_c: cover property (@(posedge clk_sys)
    st_r == S_EXEC && opc_r == CPUAM_OP_PUSH);
  post_cov_c: cover property (@(posedge clk_sys)
    st_r == S_PHI && am_r == CPUAM_AM_POST);
endmodule : cpuam_core

// ===== hdl/cpuam_decode.sv
`timescale 1ns/1ps
module cpuam_decode (
  // Address in
  input  wire logic [13:0]          addr,
  // Decoded region
  output cpuam_pkg::cpuam_dec_s     dec
);
  import cpuam_pkg::*;

  wire ram_hit = (addr >= RAM_LO) && (addr <= RAM_HI);

  assign dec.rom = (addr >= ROM_LO) && (addr <= ROM_HI);
  assign dec.ram = ram_hit;
  assign dec.zp  = ram_hit && (addr <= ZP_HI);
  assign dec.stk = ram_hit && (addr >= STK_BASE);
  assign dec.pca = (addr >= PCA_LO) && (addr <= PCA_HI);
endmodule : cpuam_decode

// ===== hdl/cpuam_pkg.sv
package cpuam_pkg;

  localparam int PC_W     = 14;
  localparam int DATA_W   = 8;
  localparam int SP_W     = 8;

  localparam logic [13:0] ROM_LO      = 14'h2000;
  localparam logic [13:0] ROM_HI      = 14'h2fff;
  localparam logic [13:0] RST_VEC_LO  = 14'h2ffc;
  localparam logic [13:0] RST_VEC_HI  = 14'h2ffd;
  localparam logic [13:0] RAM_LO      = 14'h00a0;
  localparam logic [13:0] RAM_HI      = 14'h011f;
  localparam logic [13:0] ZP_HI       = 14'h00ff;
  localparam logic [13:0] STK_BASE    = 14'h0100;
  localparam logic [13:0] PCA_LO      = 14'h0000;
  localparam logic [13:0] PCA_HI      = 14'h0022;
  localparam int          ROM_DEPTH   = 4096;
  localparam int          RAM_DEPTH   = 128;
  localparam logic [7:0]  FLAGS_RST   = 8'h20;
  localparam logic [7:0]  FLAGS_MASK  = 8'hef;

  typedef enum logic [1:0] {
    CPUAM_REG_X = 2'h0,
    CPUAM_REG_Y = 2'h1
  } cpuam_idx_e;

  typedef enum logic [3:0] {
    CPUAM_OP_NOP  = 4'h0,
    CPUAM_OP_LDW  = 4'h1,
    CPUAM_OP_STW  = 4'h2,
    CPUAM_OP_PUSH = 4'h3,
    CPUAM_OP_PULL = 4'h4,
    CPUAM_OP_LDX  = 4'h5,
    CPUAM_OP_LDY  = 4'h6,
    CPUAM_OP_LDSP = 4'h7,
    CPUAM_OP_ADD  = 4'h8,
    CPUAM_OP_XCHX = 4'h9,
    CPUAM_OP_JMP  = 4'ha,
    CPUAM_OP_BRZ  = 4'hb,
    CPUAM_OP_LDF  = 4'hc
  } cpuam_op_e;

  typedef enum logic [1:0] {
    CPUAM_AM_ABS  = 2'h0,
    CPUAM_AM_IDX  = 2'h1,
    CPUAM_AM_PRE  = 2'h2,
    CPUAM_AM_POST = 2'h3
  } cpuam_am_e;

  typedef struct packed {
    logic        pca;
    logic        ram;
    logic        zp;
    logic        stk;
    logic        rom;
  } cpuam_dec_s;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [13:0] addr;
    logic [7:0]  wdata;
  } cpuam_pca_s;

  typedef struct packed {
    logic [7:0]  work;
    logic [7:0]  flags;
    logic [7:0]  sp;
    logic [13:0] pc;
  } cpuam_state_s;

endpackage : cpuam_pkg

// ===== hdl/cpuam_ram.sv
`timescale 1ns/1ps
module cpuam_ram #(
  parameter int DEPTH = cpuam_pkg::RAM_DEPTH
) (
  // Clock
  input  wire logic                     clk_sys,
  // Access
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [7:0]               wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [7:0]               rdata
);
  import cpuam_pkg::*;

  // Plain storage; contents are undefined after power-up by design.
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule : cpuam_ram
